// File: verilog/dcd_dma.sv
// ------------------------------------------------------------
// Notes on behaviour
// (RULE1) one descriptor copies source to sink
// (RULE2) descriptor may name itself as successor
// (RULE3) double buffering through two linked descriptors
// (RULE4) finished descriptor starts its named successor
// (RULE5) last of longer chain may link first
// (RULE6) fetch descriptor writes address into later one
// (RULE7) next descriptor runs with freshly written address
// (RULE8) each descriptor covers one scatter-gather segment
// (RULE9) software prepares configuration-phase copy descriptor
// (RULE10) status-phase descriptor copies peripheral status out
// (RULE11) phase sub-chains link into longer chains
// (RULE12) descriptor storage is mapped on system bus
// (RULE13) descriptors may load and call each other
// (RULE14) completed descriptor may kick another channel
// (RULE15) 24 channels share 128 descriptors
// (RULE16) length unbounded or 1..64k, bursts 1..127
// (RULE17) higher priority waits for transaction end
// (RULE18) equal priority ties shared round robin
// (RULE19) last-marked descriptor stops channel, signals done
// (RULE20) descriptor refetched at every start
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dcd_dma
   import dcd_pkg::*;
#(
   parameter int NUM_CH = DCD_NUM_CH,
   parameter int NUM_TD = DCD_NUM_TD
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [NUM_CH-1:0] ch_req,
   input wire logic cfg_ch_wr,
   input wire logic [DCD_CH_W-1:0] cfg_ch,
   input wire logic cfg_ch_en,
   input wire logic [DCD_TD_W-1:0] cfg_first_td,
   input wire logic [DCD_PRIO_W-1:0] cfg_prio,
   input wire logic cfg_rr_dis,
   input wire logic td_wr,
   input wire logic [DCD_MEM_AW-1:0] td_wr_addr,
   input wire logic [31:0] td_wr_data,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata,
   output logic bus_req,
   output logic bus_we,
   output logic [31:0] bus_addr,
   output logic [31:0] bus_wdata,
   output logic [NUM_CH-1:0] ch_done,
   output logic [NUM_CH-1:0] ch_active,
   output logic busy
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // descriptor pool shared by all channels, four words each
   logic [31:0] td_mem [0:NUM_TD*DCD_WORDS_PER_TD-1]; // RULE15
   logic [DCD_TD_W-1:0] ch_td_q [0:NUM_CH-1];
   logic [DCD_CNT_W-1:0] ch_cnt_q [0:NUM_CH-1];
   logic [DCD_PRIO_W-1:0] ch_prio_q [0:NUM_CH-1];
   logic [NUM_CH-1:0] ch_rr_dis_q, pend_q, act_q, done_q;
   logic [DCD_CH_W-1:0] rr_q, sel_q;
   dcd_state_t state_q;
   logic [31:0] w0_q, w1_q, w2_q, w3_q, data_q;
   logic [DCD_BURST_W-1:0] bcnt_q;
   logic req_q, we_q, busy_q;
   logic [31:0] addr_q, wdata_q;

   // ------------------------------------------------------------
   // arbiter
   // ------------------------------------------------------------
   // lowest priority number wins; ties go in rotated order from rr_q,
   // and a channel with rotation disabled always heads its level
   logic grant_ok;
   logic [DCD_CH_W-1:0] grant_ch;
   always_comb begin
      logic [DCD_PRIO_W:0] best;
      logic [DCD_CH_W-1:0] idx;
      logic [DCD_PRIO_W:0] key;
      best = '1;
      idx = '0;
      key = '0;
      grant_ok = 1'b0;
      grant_ch = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         idx = DCD_CH_W'((int'(rr_q) + i) % NUM_CH);
         key = {ch_prio_q[idx], ~ch_rr_dis_q[idx]};
         if (pend_q[idx] && act_q[idx] && (!grant_ok || key < best)) begin // RULE17 RULE18
            best = key;
            grant_ch = idx;
            grant_ok = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // descriptor decode and address selection
   // ------------------------------------------------------------
   wire [DCD_MEM_AW-1:0] td_base = {ch_td_q[grant_ch], 2'b00};
   wire [15:0] len_f = w2_q[DCD_W2_LEN_LSB +: 16];
   wire [DCD_BURST_W-1:0] burst_f = w2_q[DCD_W2_BURST_LSB +: DCD_BURST_W];
   wire inf_f = w2_q[DCD_W2_INF_BIT];
   wire last_f = w2_q[DCD_W2_LAST_BIT];
   wire [DCD_TD_W-1:0] next_f = w2_q[DCD_W2_NEXT_LSB +: DCD_TD_W];
   wire chain_f = w3_q[DCD_W3_CHAIN_BIT];
   wire [DCD_CH_W-1:0] chain_ch_f = w3_q[DCD_W3_CHAIN_LSB +: DCD_CH_W];
   // a zero length field stands for the full 64k bytes
   wire [DCD_CNT_W-1:0] len_bytes = (len_f == 16'h0000) ? DCD_LEN_ZERO : {1'b0, len_f}; // RULE16
   wire [DCD_CNT_W-1:0] cnt_cur = ch_cnt_q[sel_q];
   wire [31:0] src_addr = w0_q + (w3_q[DCD_W3_SRC_INC_BIT] ? {15'h0000, cnt_cur} : 32'h00000000); // RULE8
   wire [31:0] dst_addr = w1_q + (w3_q[DCD_W3_DST_INC_BIT] ? {15'h0000, cnt_cur} : 32'h00000000); // RULE8
   // descriptor pool answers on the bus window itself, no bus cycle needed
   wire src_int = (src_addr[31:16] == DCD_TD_BASE_HI); // RULE12
   wire dst_int = (dst_addr[31:16] == DCD_TD_BASE_HI); // RULE12
   wire [DCD_CNT_W-1:0] cnt_nxt = cnt_cur + DCD_STEP;
   // one extra bit so a 127-byte burst cannot wrap past its end
   wire [DCD_BURST_W:0] bcnt_nxt = {1'b0, bcnt_q} + (DCD_BURST_W+1)'(4);
   wire td_end = !inf_f && (cnt_nxt >= len_bytes); // RULE16
   // burst field of zero means no burst split inside the descriptor
   wire burst_end = (burst_f != '0) && (bcnt_nxt >= {1'b0, burst_f}); // RULE16
   wire wr_done = (state_q == DCD_WR) && (dst_int || (req_q && bus_ack));
   wire take = (state_q == DCD_IDLE) && grant_ok;
   wire [NUM_CH-1:0] chain_kick = (wr_done && td_end && chain_f) ? (NUM_CH'(1) << chain_ch_f) : '0; // RULE14

   // ------------------------------------------------------------
   // descriptor pool writes
   // ------------------------------------------------------------
   // engine write wins a same-cycle clash with the loading port
   always_ff @(posedge clk_sys) begin
      if (wr_done && dst_int) begin
         td_mem[dst_addr[DCD_MEM_AW+1:2]] <= data_q; // RULE6 RULE12 RULE13
      end else if (td_wr) begin
         td_mem[td_wr_addr] <= td_wr_data; // RULE9
      end
   end

   // ------------------------------------------------------------
   // channel bookkeeping
   // ------------------------------------------------------------
   // request set wins over the clear made by taking a burst
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pend_q <= '0;
         act_q <= '0;
         done_q <= '0;
         ch_rr_dis_q <= '0;
         rr_q <= DCD_RR_RST;
         for (int c = 0; c < NUM_CH; c++) begin
            ch_td_q[c] <= '0;
            ch_cnt_q[c] <= DCD_CNT_RST;
            ch_prio_q[c] <= '0;
         end
      end else begin
         pend_q <= (pend_q & ~(take ? (NUM_CH'(1) << grant_ch) : '0)) | ch_req | chain_kick; // RULE14
         done_q <= '0;
         if (take) begin
            rr_q <= (int'(grant_ch) == NUM_CH - 1) ? '0 : grant_ch + DCD_CH_W'(1); // RULE18
         end
         if (wr_done) begin
            if (td_end) begin
               ch_cnt_q[sel_q] <= DCD_CNT_RST;
               ch_td_q[sel_q] <= next_f; // RULE2 RULE3 RULE4 RULE5 RULE7 RULE11
               if (last_f) begin
                  act_q[sel_q] <= 1'b0; // RULE19
                  done_q[sel_q] <= 1'b1; // RULE19
               end
            end else begin
               ch_cnt_q[sel_q] <= cnt_nxt;
            end
         end
         // a configuration write in the same cycle overrides the engine
         if (cfg_ch_wr) begin
            act_q[cfg_ch] <= cfg_ch_en;
            ch_td_q[cfg_ch] <= cfg_first_td;
            ch_cnt_q[cfg_ch] <= DCD_CNT_RST;
            ch_prio_q[cfg_ch] <= cfg_prio;
            ch_rr_dis_q[cfg_ch] <= cfg_rr_dis;
         end
      end
   end

   // ------------------------------------------------------------
   // transfer engine
   // ------------------------------------------------------------
   // descriptor words are read again on every start so that rewrites
   // by other descriptors or software are seen
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= DCD_IDLE;
         sel_q <= '0;
         {w0_q, w1_q, w2_q, w3_q, data_q} <= '0;
         bcnt_q <= '0;
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
         busy_q <= 1'b0;
      end else begin
         case (state_q)
            DCD_IDLE: begin
               busy_q <= grant_ok;
               if (grant_ok) begin
                  sel_q <= grant_ch;
                  w0_q <= td_mem[td_base]; // RULE20
                  w1_q <= td_mem[td_base + DCD_MEM_AW'(1)]; // RULE20
                  w2_q <= td_mem[td_base + DCD_MEM_AW'(2)]; // RULE20
                  w3_q <= td_mem[td_base + DCD_MEM_AW'(3)]; // RULE20
                  bcnt_q <= '0;
                  state_q <= DCD_RD;
               end
            end
            DCD_RD: begin
               if (src_int) begin
                  data_q <= td_mem[src_addr[DCD_MEM_AW+1:2]]; // RULE12
                  state_q <= DCD_WR;
               end else if (!req_q) begin
                  req_q <= 1'b1; // RULE1
                  we_q <= 1'b0;
                  addr_q <= src_addr;
               end else if (bus_ack) begin
                  req_q <= 1'b0;
                  data_q <= bus_rdata; // RULE10
                  state_q <= DCD_WR;
               end
            end
            DCD_WR: begin
               if (!dst_int && !req_q) begin
                  req_q <= 1'b1; // RULE1
                  we_q <= 1'b1;
                  addr_q <= dst_addr;
                  wdata_q <= data_q;
               end else if (wr_done) begin
                  req_q <= 1'b0;
                  we_q <= 1'b0;
                  bcnt_q <= bcnt_nxt[DCD_BURST_W-1:0];
                  // a transaction ends at burst or descriptor end; only then may
                  // another channel take the engine
                  state_q <= (td_end || burst_end) ? DCD_IDLE : DCD_RD; // RULE17
               end
            end
            default: state_q <= DCD_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign bus_req = req_q;
   assign bus_we = we_q;
   assign bus_addr = addr_q;
   assign bus_wdata = wdata_q;
   assign ch_done = done_q;
   assign ch_active = act_q;
   assign busy = busy_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_done_stops_ch: assert property (|done_q |=> ((act_q & $past(done_q)) == '0) || $past(cfg_ch_wr)) // RULE19
      else $error("channel still active after done");
   a_done_one_cycle: assert property (|done_q |=> $past(done_q) != done_q || done_q == '0) // RULE19
      else $error("done held longer than one cycle");
   a_grant_prio: assert property (take |-> (ch_prio_q[grant_ch] <= ch_prio_q[rr_q] || !pend_q[rr_q] || !act_q[rr_q])) // RULE17
      else $error("lower priority channel granted");
   a_no_preempt: assert property (state_q == DCD_RD && $past(state_q) == DCD_WR |-> sel_q == $past(sel_q)) // RULE17
      else $error("channel switched inside transaction");
   a_rr_advance: assert property (take |=> rr_q == ((int'($past(grant_ch)) == NUM_CH - 1) ? '0 : $past(grant_ch) + 1'b1)) // RULE18
      else $error("round robin pointer wrong");
   a_succ_load: assert property (wr_done && td_end && !cfg_ch_wr |=> ch_td_q[$past(sel_q)] == $past(next_f)) // RULE4
      else $error("successor descriptor not loaded");
   a_req_hold: assert property (req_q && !bus_ack |=> req_q && $stable(addr_q) && $stable(we_q)) // RULE1
      else $error("bus request dropped before answer");
   a_int_write: assert property (wr_done && dst_int |=> td_mem[$past(dst_addr[DCD_MEM_AW+1:2])] == $past(data_q)) // RULE12
      else $error("descriptor pool write lost");
   a_chain_kick: assert property (wr_done && td_end && chain_f |=> pend_q[$past(chain_ch_f)]) // RULE14
      else $error("chained channel not kicked");
   a_idle_no_req: assert property (state_q == DCD_IDLE |-> !req_q) // RULE16
      else $error("bus request outside transfer");
endmodule
`default_nettype wire

// File: verilog/dcd_pkg.sv
`default_nettype none
package dcd_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int DCD_NUM_CH = 24;
   localparam int DCD_NUM_TD = 128;
   localparam int DCD_CH_W = 5;
   localparam int DCD_TD_W = 7;
   localparam int DCD_PRIO_W = 3;
   localparam int DCD_CNT_W = 17;
   localparam int DCD_BURST_W = 7;
   localparam int DCD_WORDS_PER_TD = 4;
   localparam int DCD_MEM_AW = 9;
   // ------------------------------------------------------------
   // descriptor window on the system bus and transfer step
   // ------------------------------------------------------------
   localparam logic [15:0] DCD_TD_BASE_HI = 16'h4000;
   localparam logic [DCD_CNT_W-1:0] DCD_STEP = 17'h00004;
   localparam logic [DCD_CNT_W-1:0] DCD_LEN_ZERO = 17'h10000;
   // ------------------------------------------------------------
   // descriptor word 2 fields (length, burst, flags, successor)
   // ------------------------------------------------------------
   localparam int DCD_W2_LEN_LSB = 0;
   localparam int DCD_W2_BURST_LSB = 16;
   localparam int DCD_W2_INF_BIT = 23;
   localparam int DCD_W2_LAST_BIT = 24;
   localparam int DCD_W2_NEXT_LSB = 25;
   // ------------------------------------------------------------
   // descriptor word 3 fields (address steps, channel chaining)
   // ------------------------------------------------------------
   localparam int DCD_W3_SRC_INC_BIT = 0;
   localparam int DCD_W3_DST_INC_BIT = 1;
   localparam int DCD_W3_CHAIN_BIT = 2;
   localparam int DCD_W3_CHAIN_LSB = 3;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [DCD_CH_W-1:0] DCD_RR_RST = 5'h00;
   localparam logic [DCD_CNT_W-1:0] DCD_CNT_RST = 17'h00000;
   typedef enum logic [1:0] {DCD_IDLE, DCD_RD, DCD_WR} dcd_state_t;
endpackage
`default_nettype wire

// File: test/dcd_bus_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// system bus partner: memory and peripheral registers
// ------------------------------------------------------------
module dcd_bus_mem (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] lat,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   output logic bus_ack,
   output logic [31:0] bus_rdata
);
   logic [31:0] mem [0:255];
   logic [3:0] wait_q;
   wire logic [7:0] idx;
   assign idx = bus_addr[9:2];
   // answer after lat idle cycles; read data only valid with ack,
   // otherwise it toggles so a late sample cannot pass by luck
   always @(posedge clk_sys) begin
      if (rst) begin
         bus_ack <= 1'b0;
         wait_q <= 4'h0;
         bus_rdata <= 32'hA5A5_A5A5;
      end else if (bus_req && !bus_ack && wait_q == lat) begin
         bus_ack <= 1'b1;
         wait_q <= 4'h0;
         if (bus_we) begin
            mem[idx] <= bus_wdata;
         end else begin
            bus_rdata <= mem[idx];
         end
      end else begin
         bus_ack <= 1'b0;
         wait_q <= (bus_req && !bus_ack) ? wait_q + 4'h1 : 4'h0;
         bus_rdata <= ~bus_rdata;
      end
   end
endmodule
`default_nettype wire

// File: test/tb_dcd_dma.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dcd_dma;
   import dcd_pkg::*;
   logic clk_sys, rst, cfg_ch_wr, cfg_ch_en, cfg_rr_dis, td_wr, bus_ack, bus_req, bus_we, busy;
   logic [23:0] ch_req, ch_done, ch_active;
   logic [DCD_CH_W-1:0] cfg_ch;
   logic [DCD_TD_W-1:0] cfg_first_td;
   logic [DCD_PRIO_W-1:0] cfg_prio;
   logic [DCD_MEM_AW-1:0] td_wr_addr;
   logic [31:0] td_wr_data, bus_rdata, bus_addr, bus_wdata;
   logic [3:0] lat;
   int n_fail, check_count, cyc;
   dcd_dma dut_u (.clk_sys(clk_sys), .rst(rst), .ch_req(ch_req), .cfg_ch_wr(cfg_ch_wr), .cfg_ch(cfg_ch),
      .cfg_ch_en(cfg_ch_en), .cfg_first_td(cfg_first_td), .cfg_prio(cfg_prio), .cfg_rr_dis(cfg_rr_dis),
      .td_wr(td_wr), .td_wr_addr(td_wr_addr), .td_wr_data(td_wr_data), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .ch_done(ch_done), .ch_active(ch_active), .busy(busy));
   dcd_bus_mem bus_u (.clk_sys(clk_sys), .rst(rst), .lat(lat), .bus_req(bus_req), .bus_we(bus_we),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
   // ------------------------------------------------------------
   // clock, timeout and verdict
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic end_of_test();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // whole run is a few hundred cycles; far ceiling catches a hang
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one word, no burst split, successor and last flag
   function automatic logic [31:0] w2(input logic [6:0] nxt, input logic last);
      return {nxt, last, 1'b0, 7'h00, 16'h0004};
   endfunction
   task automatic tdw(input int td, input logic [31:0] src, input logic [31:0] dst, input logic [31:0] w,
      input logic [31:0] w3 = 32'h0000_0003);
      logic [31:0] words [4];
      words = '{src, dst, w, w3};
      for (int k = 0; k < 4; k++) begin
         @(negedge clk_sys);
         td_wr = 1'b1;
         td_wr_addr = 9'(td * 4 + k);
         td_wr_data = words[k];
      end
      @(negedge clk_sys);
      td_wr = 1'b0;
   endtask
   task automatic cfg(input int ch, input int td, input int prio);
      @(negedge clk_sys);
      cfg_ch_wr = 1'b1;
      cfg_ch = 5'(ch);
      cfg_ch_en = 1'b1;
      cfg_first_td = 7'(td);
      cfg_prio = 3'(prio);
      @(negedge clk_sys);
      cfg_ch_wr = 0;
      chk({31'h0, ch_active[ch]}, 32'h1);
   endtask
   // request held as a level so every descriptor start finds it pending
   task automatic wait_done(input int ch);
      for (int i = 0; i < 400 && ch_done[ch] !== 1'b1; i++) @(negedge clk_sys);
      chk({31'h0, ch_done[ch]}, 32'h1);
      @(negedge clk_sys);
      chk({31'h0, ch_active[ch]}, 32'h0);
      ch_req[ch] = 1'b0;
   endtask
   task automatic run(input int ch);
      @(negedge clk_sys);
      ch_req[ch] = 1'b1;
      wait_done(ch);
      chk({31'h0, busy}, 32'h0);
   endtask
   // completion of channel 7 kicks channel 8, which was never requested
   task automatic s_kick();
      lat = 4'h1;
      bus_u.mem[84] = 32'h7777_0007;
      bus_u.mem[85] = 32'h8888_0008;
      tdw(7, 32'h150, 32'h250, w2(7, 1), 32'h0000_0047);
      tdw(8, 32'h154, 32'h254, w2(8, 1));
      cfg(7, 7, 2);
      cfg(8, 8, 2);
      @(negedge clk_sys);
      ch_req[7] = 1'b1;
      wait_done(7);
      wait_done(8);
      chk(bus_u.mem[148], 32'h7777_0007);
      chk(bus_u.mem[149], 32'h8888_0008);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic s_simple();
      lat = 4'h0;
      bus_u.mem[64] = 32'h1111_0001;
      bus_u.mem[65] = 32'h2222_0002;
      tdw(0, 32'h100, 32'h200, w2(0, 1));
      cfg(0, 0, 2);
      run(0);
      chk(bus_u.mem[128], 32'h1111_0001);
      tdw(0, 32'h104, 32'h200, w2(0, 1));
      cfg(0, 0, 2);
      run(0);
      chk(bus_u.mem[128], 32'h2222_0002);
   endtask
   task automatic s_chain();
      lat = 4'h3;
      bus_u.mem[68] = 32'h3333_0003;
      bus_u.mem[72] = 32'h4444_0004;
      tdw(1, 32'h110, 32'h210, w2(2, 0));
      tdw(2, 32'h120, 32'h214, w2(0, 1));
      cfg(1, 1, 1);
      run(1);
      chk(bus_u.mem[132], 32'h3333_0003);
      chk(bus_u.mem[133], 32'h4444_0004);
   endtask
   // first descriptor copies a peripheral address into word0 of the next
   task automatic s_index();
      lat = 4'h1;
      bus_u.mem[96] = 32'h0000_0140;
      bus_u.mem[80] = 32'hCAFE_0003;
      tdw(3, 32'h180, 32'h4000_0040, w2(4, 0));
      tdw(4, 32'h0, 32'h300, w2(0, 1));
      cfg(4, 3, 4);
      run(4);
      chk(bus_u.mem[192], 32'hCAFE_0003);
   endtask
   task automatic s_prio();
      lat = 4'h2;
      bus_u.mem[76] = 32'h5555_0005;
      bus_u.mem[77] = 32'h6666_0006;
      tdw(5, 32'h130, 32'h230, w2(5, 1));
      tdw(6, 32'h134, 32'h234, w2(6, 1));
      cfg(5, 5, 3);
      cfg(6, 6, 0);
      @(negedge clk_sys);
      ch_req[5] = 1'b1;
      ch_req[6] = 1'b1;
      for (int i = 0; i < 50 && bus_req !== 1'b1; i++) @(negedge clk_sys);
      chk(bus_addr, 32'h134);
      wait_done(6);
      wait_done(5);
      chk(bus_u.mem[140], 32'h5555_0005);
      chk(bus_u.mem[141], 32'h6666_0006);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {rst, cfg_ch_wr, cfg_ch_en, cfg_rr_dis, td_wr} = 5'h10;
      {ch_req, cfg_ch, cfg_first_td, cfg_prio, td_wr_addr, td_wr_data, lat} = '0;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      chk({31'h0, bus_req}, 32'h0);
      s_simple();
      s_kick();
      s_chain();
      s_index();
      s_prio();
      end_of_test();
   end
endmodule
`default_nettype wire
